/* hw/fre_regs.sv */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
// Contract
// [RQ1] Eight erase-select bits, reset 0; a 1 selects that flash block for erase.
// [RQ2] Erase select read-only in modes 1-4, writable 5-7; mode 6 writes never set ones.
// [RQ3] Software keeps erase select at all zeros whenever no erase is running.
// [RQ4] Mask-ROM version: both registers read all ones and ignore writes.
// [RQ5] Emulation enable 0: RAM window stays at fff000-fff3ff, area bits ignored.
// [RQ6] Emulation enable 1: window maps to 000000/000400/000800/000c00 by area bits.
// [RQ7] In mode 6 software may write the RAM control bits but never sets them.
// [RQ8] In mode 6 the system holds the flash write enable pin low.
// [RQ9] RAM control bits reset 0, read-only modes 1-4, writable 5-7; reserved read 1.
module fre_regs
  import fre_pkg::*;
(
  input  wire logic              CLOCK,     // 125 MHz system clock
  input  wire logic              RST,       // Synchronous reset, active high
  input  wire logic [2:0]        MODE,      // Operating mode 1..7
  input  wire logic              MASK_ROM,  // High on the mask-ROM version
  input  wire logic [11:0]       AWADDR,    // Write address
  input  wire logic [2:0]        AWPROT,    // Write protection, unused
  input  wire logic              AWVALID,   // Write address valid
  output logic                   AWREADY,   // Write address ready
  input  wire logic [31:0]       WDATA,     // Write data
  input  wire logic [3:0]        WSTRB,     // Write byte strobes
  input  wire logic              WVALID,    // Write data valid
  output logic                   WREADY,    // Write data ready
  output logic [1:0]             BRESP,     // Write response
  output logic                   BVALID,    // Write response valid
  input  wire logic              BREADY,    // Write response ready
  input  wire logic [11:0]       ARADDR,    // Read address
  input  wire logic [2:0]        ARPROT,    // Read protection, unused
  input  wire logic              ARVALID,   // Read address valid
  output logic                   ARREADY,   // Read address ready
  output logic [31:0]            RDATA,     // Read data
  output logic [1:0]             RRESP,     // Read response
  output logic                   RVALID,    // Read data valid
  input  wire logic              RREADY,    // Read data ready
  output logic [7:0]             ERASE_SEL, // Flash blocks selected for erase
  output fre_pkg::fre_win_t      RAM_WIN    // RAM window placement
);

  // =====================================================================
  // Helpers
  // =====================================================================
  function automatic fre_reg_t fre_decode(input logic [11:0] addr);
    if (addr[11:2] == FRE_ADDR_ERASE_SEL[11:2]) begin
      fre_decode = FRE_REG_ERASE;
    end else if (addr[11:2] == FRE_ADDR_RAM_CTRL[11:2]) begin
      fre_decode = FRE_REG_RAM;
    end else begin
      fre_decode = FRE_REG_NONE;
    end
  endfunction

  function automatic logic fre_mode_wr(input logic [2:0] mode);
    fre_mode_wr = (mode >= FRE_MODE_WR_MIN);
  endfunction

  function automatic logic [1:0] fre_resp(input fre_reg_t sel);
    if (sel == FRE_REG_NONE) begin
      fre_resp = FRE_RESP_DECERR;
    end else begin
      fre_resp = FRE_RESP_OKAY;
    end
  endfunction

  function automatic fre_win_t fre_win_place(input logic [2:0] ctl);
    fre_win_t win;
    win.emul_on = ctl[2];
    if (ctl[2]) begin
      win.base = FRE_WIN_FLASH + ({22'h000000, ctl[1:0]} * FRE_WIN_SIZE); // RQ6
    end else begin
      win.base = FRE_WIN_HOME; // RQ5
    end
    fre_win_place = win;
  endfunction

  // Reserved bits read as ones; the three control bits sit at 3..1
  function automatic logic [7:0] fre_ramctl_image(input logic [2:0] ctl);
    fre_ramctl_image = FRE_RAMCTL_RSVD | {4'h0, ctl, 1'b0};
  endfunction

  // =====================================================================
  // State
  // =====================================================================
  logic [7:0]  erase_q;
  logic [2:0]  ramctl_q;
  fre_win_t    win_q;
  logic        awready_q;
  logic        wready_q;
  logic        aw_full_q;
  logic        w_full_q;
  logic [11:0] aw_addr_q;
  logic [7:0]  w_data_q;
  logic        w_lane_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  logic        wr_fire;
  fre_reg_t    wr_reg;
  fre_reg_t    rd_reg;
  logic        wr_ok;
  logic [7:0]  rd_byte;

  logic        mode_rw;
  logic        mode_no_emul;
  logic [1:0]  bresp_d;

  // MODE 0 is not a real operating mode and is treated as read-only
  assign mode_rw      = fre_mode_wr(MODE);
  assign mode_no_emul = (MODE == FRE_MODE_NO_EMUL);

  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_reg  = fre_decode(aw_addr_q);
  assign rd_reg  = fre_decode(ARADDR);
  assign bresp_d = fre_resp(wr_reg);
  // Writes count only with the low lane enabled, outside mask ROM, in 5..7
  assign wr_ok   = wr_fire && w_lane_q && !MASK_ROM && mode_rw; // RQ4 RQ2 RQ9

  // =====================================================================
  // Write channels
  // =====================================================================
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end else begin
      awready_q <= 1'b0;
      if (AWVALID && !awready_q && !aw_full_q && !bvalid_q) begin
        awready_q <= 1'b1;
        aw_full_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else begin
      wready_q <= 1'b0;
      if (WVALID && !wready_q && !w_full_q && !bvalid_q) begin
        wready_q <= 1'b1;
        w_full_q <= 1'b1;
        w_data_q <= WDATA[7:0];
        w_lane_q <= WSTRB[0];
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q  <= FRE_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= bresp_d;
    end else if (bvalid_q && BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // =====================================================================
  // Erase block select
  // =====================================================================
  logic [7:0]  erase_d;
  logic        erase_wr;

  assign erase_wr = wr_ok && (wr_reg == FRE_REG_ERASE);

  always_comb begin
    erase_d = erase_q;
    if (erase_wr) begin
      // Mode 6 write can only clear: it is the way out of a stuck selection
      if (mode_no_emul) begin
        erase_d = FRE_ERASE_RST; // RQ2
      end else begin
        erase_d = w_data_q; // RQ1
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      erase_q <= FRE_ERASE_RST; // RQ1
    end else begin
      erase_q <= erase_d;
    end
  end

  // =====================================================================
  // RAM emulation control
  // =====================================================================
  logic [2:0]  ramctl_d;
  logic        ramctl_wr;
  fre_win_t    win_d;

  assign ramctl_wr = wr_ok && (wr_reg == FRE_REG_RAM);

  always_comb begin
    ramctl_d = ramctl_q;
    if (ramctl_wr) begin
      // Mode 6 takes the value as written; keeping it zero is software's job
      ramctl_d = {w_data_q[FRE_BIT_EMUL_EN],
                  w_data_q[FRE_BIT_AREA_HI],
                  w_data_q[FRE_BIT_AREA_LO]}; // RQ9 RQ7
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ramctl_q <= FRE_RAMCTL_RST; // RQ9
    end else begin
      ramctl_q <= ramctl_d;
    end
  end

  // Window placement is registered so the outputs come from flops
  assign win_d = fre_win_place(ramctl_q); // RQ5 RQ6

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      win_q.emul_on <= 1'b0;
      win_q.base    <= FRE_WIN_HOME;
    end else begin
      win_q <= win_d;
    end
  end

  // =====================================================================
  // Read channel
  // =====================================================================
  logic        rd_take;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_d;

  // A new read is not taken while the previous answer is still up
  assign rd_take = ARVALID && arready_q;
  assign rdata_d = {24'h000000, rd_byte};
  assign rresp_d = fre_resp(rd_reg);

  always_comb begin
    if (MASK_ROM) begin
      rd_byte = FRE_ROM_READ; // RQ4
    end else begin
      case (rd_reg)
        FRE_REG_ERASE: rd_byte = erase_q;
        FRE_REG_RAM:   rd_byte = fre_ramctl_image(ramctl_q); // RQ9
        FRE_REG_NONE:  rd_byte = 8'h00;
        default:       rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= FRE_RESP_OKAY;
    end else begin
      arready_q <= 1'b0;
      if (ARVALID && !arready_q && !rvalid_q) begin
        arready_q <= 1'b1;
      end
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rdata_d;
        rresp_q  <= rresp_d;
      end else if (rvalid_q && RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Outputs
  // =====================================================================
  assign AWREADY   = awready_q;
  assign WREADY    = wready_q;
  assign BVALID    = bvalid_q;
  assign BRESP     = bresp_q;
  assign ARREADY   = arready_q;
  assign RVALID    = rvalid_q;
  assign RDATA     = rdata_q;
  assign RRESP     = rresp_q;
  assign ERASE_SEL = erase_q;
  assign RAM_WIN   = win_q;

endmodule

/* hw/fre_pkg.sv */
package fre_pkg;

  // =====================================================================
  // Register map (printed offsets are register indices, byte = 4 * index)
  // =====================================================================
  localparam logic [11:0] FRE_IDX_ERASE_SEL = 12'h042;
  localparam logic [11:0] FRE_IDX_RAM_CTRL  = 12'h047;
  localparam logic [11:0] FRE_ADDR_ERASE_SEL = FRE_IDX_ERASE_SEL << 2;
  localparam logic [11:0] FRE_ADDR_RAM_CTRL  = FRE_IDX_RAM_CTRL << 2;

  // =====================================================================
  // Field layout and reset values
  // =====================================================================
  localparam int          FRE_BIT_EMUL_EN  = 3;
  localparam int          FRE_BIT_AREA_HI  = 2;
  localparam int          FRE_BIT_AREA_LO  = 1;
  localparam logic [7:0]  FRE_ERASE_RST    = 8'h00;
  localparam logic [2:0]  FRE_RAMCTL_RST   = 3'h0;
  localparam logic [7:0]  FRE_RAMCTL_RSVD  = 8'hf1;
  localparam logic [7:0]  FRE_ROM_READ     = 8'hff;

  // =====================================================================
  // Operating modes
  // =====================================================================
  localparam logic [2:0]  FRE_MODE_WR_MIN  = 3'h5;
  localparam logic [2:0]  FRE_MODE_NO_EMUL = 3'h6;

  // =====================================================================
  // RAM window placement
  // =====================================================================
  localparam logic [23:0] FRE_WIN_HOME     = 24'hfff000;
  localparam logic [23:0] FRE_WIN_FLASH    = 24'h000000;
  localparam logic [23:0] FRE_WIN_SIZE     = 24'h000400;

  // =====================================================================
  // Bus responses
  // =====================================================================
  localparam logic [1:0]  FRE_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  FRE_RESP_DECERR  = 2'h3;

  typedef enum logic [1:0] {
    FRE_REG_NONE  = 2'h0,
    FRE_REG_ERASE = 2'h1,
    FRE_REG_RAM   = 2'h3
  } fre_reg_t;

  typedef struct packed {
    logic        emul_on;
    logic [23:0] base;
  } fre_win_t;

endpackage

/* tb/fre_regs_props.sv */
`timescale 1ns/1ns
module fre_regs_props
  import fre_pkg::*;
(
  input wire logic              CLOCK,     // Clock
  input wire logic              RST,       // Reset
  input wire logic [2:0]        MODE,      // Mode
  input wire logic              MASK_ROM,  // Rom part
  input wire logic              WVALID,    // W valid
  input wire logic              WREADY,    // W ready
  input wire logic              BVALID,    // B valid
  input wire logic              RVALID,    // R valid
  input wire logic [31:0]       RDATA,     // R data
  input wire logic [7:0]        ERASE_SEL, // Erase select
  input wire fre_pkg::fre_win_t RAM_WIN    // Window
);
  // ====
  // Checks
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  AST_ERASE_RST: assert property ($past(RST) |-> ERASE_SEL == FRE_ERASE_RST)
    else $error("erase select not reset");
  // Reset edges are excluded: a short reset may change the flop with no write
  AST_ERASE_CAUSE: assert property ($changed(ERASE_SEL) && !$past(RST) |-> $past(WVALID && WREADY))
    else $error("erase select moved without write");
  AST_RO_HOLD: assert property ((MASK_ROM || MODE < FRE_MODE_WR_MIN) && $stable(MODE)
    && $stable(MASK_ROM) |-> $stable(ERASE_SEL)) else $error("read-only erase select moved");
  AST_M6_CLEAR: assert property (MODE == FRE_MODE_NO_EMUL && $stable(MODE) |->
    $stable(ERASE_SEL) || ERASE_SEL == 8'h00) else $error("mode 6 set erase bits");
  AST_WIN_HOME: assert property (!RAM_WIN.emul_on |-> RAM_WIN.base == FRE_WIN_HOME)
    else $error("window off but moved");
  AST_WIN_MAP: assert property (RAM_WIN.emul_on |-> RAM_WIN.base inside
    {24'h000000, 24'h000400, 24'h000800, 24'h000c00}) else $error("bad window base");
  AST_WIN_CAUSE: assert property ($changed(RAM_WIN) && !$past(RST) |-> $past(WVALID && WREADY, 2))
    else $error("window moved without write");
  AST_ROM_RD: assert property ($rose(RVALID) && MASK_ROM && $past(MASK_ROM) |-> RDATA[7:0] == FRE_ROM_READ)
    else $error("rom read not ones");
  AST_WR_RESP: assert property (WVALID && WREADY |-> ##[1:2] BVALID)
    else $error("no write response");
endmodule

bind fre_regs fre_regs_props chk_u (.CLOCK(CLOCK), .RST(RST), .MODE(MODE), .MASK_ROM(MASK_ROM),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .RVALID(RVALID), .RDATA(RDATA),
  .ERASE_SEL(ERASE_SEL), .RAM_WIN(RAM_WIN));

/* tb/flash_block_select_ram_emulation_bench.sv */
`timescale 1ns/1ns
module flash_block_select_ram_emulation_bench;
  import fre_pkg::*;
  logic        CLOCK = 1'b0, RST = 1'b1, MASK_ROM = 1'b0;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
  logic [31:0] WDATA = 32'h0, RDATA, rv;
  logic [2:0]  MODE = 3'h5;
  logic [1:0]  BRESP, RRESP, rs;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [7:0]  ERASE_SEL;
  fre_win_t    RAM_WIN;
  int          fails = 0, total_checks = 0;
  localparam logic [11:0] AE = FRE_ADDR_ERASE_SEL, AR = FRE_ADDR_RAM_CTRL;
  fre_regs dut_u (.CLOCK(CLOCK), .RST(RST), .MODE(MODE), .MASK_ROM(MASK_ROM), .AWADDR(AWADDR),
    .AWPROT(3'h0), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .ERASE_SEL(ERASE_SEL), .RAM_WIN(RAM_WIN));
  initial begin
    forever #4 CLOCK = ~CLOCK;
  end
  // ====
  // Bus and compare tasks
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      fails++;
      results();
    end
  endtask
  task automatic setm(input logic [2:0] m, input logic r);
    @(posedge CLOCK);
    MODE <= m;
    MASK_ROM <= r;
  endtask
  // Each valid drops by itself at its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
      AWVALID <= AWVALID & ~AWREADY;
      WVALID <= WVALID & ~WREADY;
    end while (BVALID !== 1'b1 && n < 40);
    rs = BRESP;
    BREADY <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [11:0] a);
    int n = 0;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
      ARVALID <= ARVALID & ~ARREADY;
    end while (RVALID !== 1'b1 && n < 40);
    rv = RDATA;
    rs = RRESP;
    RREADY <= 1'b0;
    tmo(n);
  endtask
  // ====
  // Scenarios
  task automatic t_erase;
    logic [7:0] e;
    for (int m = 0; m < 8; m++) begin
      setm(3'h5, 1'b0);
      wr(AE, 8'h3c);
      setm(m[2:0], 1'b0);
      wr(AE, 8'ha5);
      rd(AE);
      e = (m == 5 || m == 7) ? 8'ha5 : (m == 6) ? 8'h00 : 8'h3c;
      chk(rv, {24'h0, e});
      chk({24'h0, ERASE_SEL}, {24'h0, e});
    end
    setm(3'h5, 1'b0);
    wr(AE, 8'h00);
    $display("test erase done");
  endtask
  task automatic t_ram;
    for (int a = 0; a < 4; a++) begin
      wr(AR, 8'h08 | 8'(a << 1));
      repeat (2) @(posedge CLOCK);
      chk({7'h0, RAM_WIN}, {7'h0, 1'b1, 24'(a * 1024)});
      rd(AR);
      chk(rv, 32'hf9 | 32'(a << 1));
    end
    wr(AR, 8'h06);
    repeat (2) @(posedge CLOCK);
    chk({7'h0, RAM_WIN}, {8'h0, FRE_WIN_HOME});
    setm(3'h2, 1'b0);
    wr(AR, 8'h08);
    rd(AR);
    chk(rv, 32'hf7);
    setm(3'h6, 1'b0);
    wr(AR, 8'h00);
    $display("test ram done");
  endtask
  task automatic t_rom;
    setm(3'h5, 1'b1);
    wr(AE, 8'hff);
    rd(AE);
    chk(rv, 32'hff);
    chk({24'h0, ERASE_SEL}, 32'h0);
    rd(AR);
    chk(rv, 32'hff);
    setm(3'h5, 1'b0);
    rd(12'h000);
    chk({30'h0, rs}, {30'h0, FRE_RESP_DECERR});
    chk(rv, 32'h0);
    wr(12'h000, 8'hff);
    chk({30'h0, rs}, {30'h0, FRE_RESP_DECERR});
    $display("test rom done");
  endtask
  initial begin
    repeat (4) @(posedge CLOCK);
    RST <= 1'b0;
    rd(AE);
    chk(rv, 32'h0);
    rd(AR);
    chk(rv, 32'hf1);
    $display("test reset done");
    t_erase();
    setm(3'h5, 1'b0);
    t_ram();
    t_rom();
    results();
  end
endmodule
